// ==== hdl/swm_pkg.sv ====
// Notes on behaviour
// RQ1: Receive interrupt when enabled and level <= count
// RQ2: Receive enable clear suppresses receive interrupt
// RQ3: Transmit interrupt when enabled and level equals count
// RQ4: Transmit enable clear suppresses transmit interrupt
// RQ5: Bits 14 and 6 read zero, ignore writes
// RQ6: Levels above buffer depth never match
// RQ7: Level bits 2-4 exist per buffer depth
// RQ8: Compare against live counts every cycle; the registered outputs and status update only in cycles with clk_en high
package swm_pkg;
    localparam logic [3:0]  OFF_MASK_HIGH  = 4'h0;
    localparam logic [3:0]  OFF_IRQ_STATUS = 4'h4;
    localparam logic [3:0]  OFF_IRQ_ENABLE = 4'h8;
    localparam logic [3:0]  OFF_LIVE       = 4'hC;
    localparam int          RX_EN_BIT      = 15;
    localparam int          RX_LVL_LSB     = 8;
    localparam int          TX_EN_BIT      = 7;
    localparam int          TX_LVL_LSB     = 0;
    localparam logic [15:0] MASK_RESET     = 16'h0000;
    localparam logic [1:0]  STATUS_RESET   = 2'h0;
    localparam int          DEPTH_BIT2     = 8;
    localparam int          DEPTH_BIT3     = 16;
    localparam int          DEPTH_BIT4     = 32;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef struct packed {
        logic       rx_watermark_irq_enable;
        logic [5:0] rx_watermark_level;
        logic       tx_watermark_irq_enable;
        logic [5:0] tx_watermark_level;
    } swm_cfg_s;

    typedef struct packed {
        logic [5:0] rx_element_count;
        logic [5:0] tx_element_count;
    } swm_count_s;

    // Writable level bits for a buffer capacity
    function automatic logic [5:0] swm_level_mask(input logic [6:0] cap);
        logic [5:0] m;
        m = 6'h23;
        if (cap >= 7'(DEPTH_BIT2))
            m[2] = 1'b1;
        if (cap >= 7'(DEPTH_BIT3))
            m[3] = 1'b1;
        if (cap >= 7'(DEPTH_BIT4))
            m[4] = 1'b1;
        return m;
    endfunction : swm_level_mask
endpackage : swm_pkg

// ==== hdl/swm_match.sv ====
`timescale 1ns/100ps
`default_nettype none
module swm_match (
    input  wire  swm_pkg::swm_cfg_s   cfg,
    input  wire  swm_pkg::swm_count_s cnt,
    input  wire  logic [6:0]          buffer_capacity,
    output logic                      rx_hit,
    output logic                      tx_hit
);
    logic rx_valid;
    logic tx_valid;

    // Out-of-range levels are invalid and never match
    assign rx_valid = {1'b0, cfg.rx_watermark_level} <= buffer_capacity; // see RQ6
    assign tx_valid = {1'b0, cfg.tx_watermark_level} <= buffer_capacity; // see RQ6
    assign rx_hit   = cfg.rx_watermark_irq_enable && rx_valid
                      && (cfg.rx_watermark_level <= cnt.rx_element_count); // see RQ1, see RQ2
    assign tx_hit   = cfg.tx_watermark_irq_enable && tx_valid
                      && (cfg.tx_watermark_level == cnt.tx_element_count); // see RQ3, see RQ4
endmodule : swm_match
`default_nettype wire

// ==== hdl/swm_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module swm_top #(
    parameter logic [6:0] BUFFER_CAPACITY = 7'h20
) (
    input  wire  logic        aclk,
    input  wire  logic        aresetn,
    input  wire  logic        clk_en,
    input  wire  logic [5:0]  rx_element_count,
    input  wire  logic [5:0]  tx_element_count,
    input  wire  logic [3:0]  s_axi_awaddr,
    input  wire  logic        s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire  logic [31:0] s_axi_wdata,
    input  wire  logic [3:0]  s_axi_wstrb,
    input  wire  logic        s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire  logic        s_axi_bready,
    input  wire  logic [3:0]  s_axi_araddr,
    input  wire  logic        s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire  logic        s_axi_rready,
    output logic              rx_watermark_irq,
    output logic              tx_watermark_irq,
    output logic              irq
);
    typedef struct packed {
        swm_pkg::swm_cfg_s   cfg;
        logic [1:0]          status;
        logic [1:0]          enable;
        logic                aw_got;
        logic [3:0]          aw_addr;
        logic                w_got;
        logic [31:0]         w_data;
        logic [3:0]          w_strb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        logic                rx_irq;
        logic                tx_irq;
        logic                irq;
        logic                awready;
        logic                wready;
        logic                arready;
    } swm_state_s;

    swm_state_s          st;
    swm_state_s          next_st;
    swm_pkg::swm_count_s cnt;
    logic                rx_hit;
    logic                tx_hit;

    assign cnt.rx_element_count = rx_element_count; // see RQ8
    assign cnt.tx_element_count = tx_element_count; // see RQ8

    swm_match i_swm_match (
        .cfg             (st.cfg),
        .cnt             (cnt),
        .buffer_capacity (BUFFER_CAPACITY),
        .rx_hit          (rx_hit),
        .tx_hit          (tx_hit)
    );

    function automatic logic [15:0] mask_word(input swm_pkg::swm_cfg_s c);
        logic [15:0] w;
        w = 16'h0000;
        w[swm_pkg::RX_EN_BIT] = c.rx_watermark_irq_enable;
        w[swm_pkg::RX_LVL_LSB +: 6] = c.rx_watermark_level;
        w[swm_pkg::TX_EN_BIT] = c.tx_watermark_irq_enable;
        w[swm_pkg::TX_LVL_LSB +: 6] = c.tx_watermark_level;
        return w; // see RQ5
    endfunction : mask_word

    always_comb
    begin
        logic [5:0]  lm;
        logic [15:0] mw;
        next_st = st;
        lm      = swm_pkg::swm_level_mask(BUFFER_CAPACITY);
        mw      = mask_word(st.cfg);
        if (s_axi_awvalid && !st.aw_got && !st.bvalid)
        begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_got && !st.bvalid)
        begin
            next_st.w_got  = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;
        // Sticky status; hardware set wins over a clearing write
        if (st.aw_got && st.w_got && !st.bvalid)
        begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = swm_pkg::RESP_OKAY;
            case (st.aw_addr)
                swm_pkg::OFF_MASK_HIGH:
                begin
                    if (st.w_strb[1])
                    begin
                        next_st.cfg.rx_watermark_irq_enable = st.w_data[swm_pkg::RX_EN_BIT];
                        next_st.cfg.rx_watermark_level = st.w_data[swm_pkg::RX_LVL_LSB +: 6] & lm; // see RQ7
                    end
                    if (st.w_strb[0])
                    begin
                        next_st.cfg.tx_watermark_irq_enable = st.w_data[swm_pkg::TX_EN_BIT];
                        next_st.cfg.tx_watermark_level = st.w_data[swm_pkg::TX_LVL_LSB +: 6] & lm; // see RQ7
                    end
                end
                swm_pkg::OFF_IRQ_STATUS:
                    if (st.w_strb[0])
                        next_st.status = st.status & ~st.w_data[1:0];
                swm_pkg::OFF_IRQ_ENABLE:
                    if (st.w_strb[0])
                        next_st.enable = st.w_data[1:0];
                swm_pkg::OFF_LIVE:
                    next_st.bresp = swm_pkg::RESP_OKAY;
                default:
                    next_st.bresp = swm_pkg::RESP_SLVERR;
            endcase
        end
        next_st.status = next_st.status | {tx_hit, rx_hit};
        if (st.rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;
        if (s_axi_arvalid && !st.rvalid)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = swm_pkg::RESP_OKAY;
            case (s_axi_araddr)
                swm_pkg::OFF_MASK_HIGH:  next_st.rdata = {16'h0000, mw};
                swm_pkg::OFF_IRQ_STATUS: next_st.rdata = {30'h00000000, st.status};
                swm_pkg::OFF_IRQ_ENABLE: next_st.rdata = {30'h00000000, st.enable};
                swm_pkg::OFF_LIVE:       next_st.rdata = {18'h00000, tx_element_count, 2'h0, rx_element_count};
                default:
                begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = swm_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_st.rx_irq = rx_hit;
        next_st.tx_irq = tx_hit;
        next_st.irq    = |(next_st.status & next_st.enable);
        // Readies come from the next state so they stay in step with the held items
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready  = !next_st.w_got && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st                             <= '0;
            st.cfg.rx_watermark_irq_enable <= swm_pkg::MASK_RESET[swm_pkg::RX_EN_BIT];
            st.cfg.rx_watermark_level      <= swm_pkg::MASK_RESET[swm_pkg::RX_LVL_LSB +: 6];
            st.cfg.tx_watermark_irq_enable <= swm_pkg::MASK_RESET[swm_pkg::TX_EN_BIT];
            st.cfg.tx_watermark_level      <= swm_pkg::MASK_RESET[swm_pkg::TX_LVL_LSB +: 6];
            st.status                      <= swm_pkg::STATUS_RESET;
            st.awready                     <= 1'b1;
            st.wready                      <= 1'b1;
            st.arready                     <= 1'b1;
        end
        else if (clk_en)
            st <= next_st;
    end

    assign s_axi_awready    = st.awready;
    assign s_axi_wready     = st.wready;
    assign s_axi_bvalid     = st.bvalid;
    assign s_axi_bresp      = st.bresp;
    assign s_axi_arready    = st.arready;
    assign s_axi_rvalid     = st.rvalid;
    assign s_axi_rdata      = st.rdata;
    assign s_axi_rresp      = st.rresp;
    assign rx_watermark_irq = st.rx_irq;
    assign tx_watermark_irq = st.tx_irq;
    assign irq              = st.irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_RX_FIRE: assert property (clk_en && st.cfg.rx_watermark_irq_enable
        && st.cfg.rx_watermark_level <= rx_element_count && {1'b0, st.cfg.rx_watermark_level} <= BUFFER_CAPACITY
        |=> rx_watermark_irq) // see RQ1
        else $error("Receive watermark did not fire");
    AST_RX_OFF: assert property (clk_en && !st.cfg.rx_watermark_irq_enable |=> !rx_watermark_irq) // see RQ2
        else $error("Receive watermark fired while disabled");
    AST_TX_FIRE: assert property (clk_en && st.cfg.tx_watermark_irq_enable
        && st.cfg.tx_watermark_level == tx_element_count && {1'b0, st.cfg.tx_watermark_level} <= BUFFER_CAPACITY
        |=> tx_watermark_irq) // see RQ3
        else $error("Transmit watermark did not fire");
    AST_TX_EXACT: assert property (clk_en && st.cfg.tx_watermark_level != tx_element_count
        |=> !tx_watermark_irq) // see RQ3
        else $error("Transmit watermark fired without equality");
    AST_TX_OFF: assert property (clk_en && !st.cfg.tx_watermark_irq_enable |=> !tx_watermark_irq) // see RQ4
        else $error("Transmit watermark fired while disabled");
    AST_RSVD_ZERO: assert property (s_axi_rvalid && $rose(s_axi_rvalid) && $past(s_axi_araddr) == swm_pkg::OFF_MASK_HIGH
        |-> s_axi_rdata[14] == 1'b0 && s_axi_rdata[6] == 1'b0) // see RQ5
        else $error("Unimplemented mask bit read as one");
    AST_RANGE: assert property (clk_en && {1'b0, st.cfg.rx_watermark_level} > BUFFER_CAPACITY
        |=> !rx_watermark_irq) // see RQ6
        else $error("Out-of-range receive level matched");
    AST_LVL_BITS: assert property ((st.cfg.rx_watermark_level & ~swm_pkg::swm_level_mask(BUFFER_CAPACITY)) == 6'h00
        && (st.cfg.tx_watermark_level & ~swm_pkg::swm_level_mask(BUFFER_CAPACITY)) == 6'h00) // see RQ7
        else $error("Absent level bit is set");
    AST_STICKY: assert property (clk_en && rx_hit |=> st.status[0]) // see RQ8
        else $error("Receive status not latched");
    AST_IRQ: assert property (clk_en && |(next_st.status & next_st.enable) |=> irq)
        else $error("Interrupt output not raised");

    COV_RX: cover property (rx_watermark_irq);
    COV_TX: cover property (tx_watermark_irq);
    COV_IRQ: cover property ($rose(irq));
    COV_WR: cover property (s_axi_bvalid && s_axi_bready);
endmodule : swm_top
`default_nettype wire

// ==== bench/swm_top_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module swm_top_bench;
    // Capacity 16 leaves level bit 4 absent, so masking and invalid levels show
    localparam logic [6:0] CAP = 7'h10;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        clk_en = 1'b1;
    logic [5:0]  rx_element_count = 6'h00;
    logic [5:0]  tx_element_count = 6'h00;
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic        rx_watermark_irq;
    logic        tx_watermark_irq;
    logic        irq;
    int          num_errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    logic [31:0] rd_val;
    logic [1:0]  resp;

    swm_top #(.BUFFER_CAPACITY(CAP)) i_swm_top (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .rx_element_count(rx_element_count), .tx_element_count(tx_element_count),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .rx_watermark_irq(rx_watermark_irq), .tx_watermark_irq(tx_watermark_irq), .irq(irq)
    );

    always #10 aclk = ~aclk;

    task automatic stop_test;
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    always @(posedge aclk)
    begin
        cycles++;
        // Whole run needs well under this; a stuck handshake lands here
        if (cycles == 5000)
        begin
            num_errors++;
            stop_test();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_val = s_axi_rdata;
        resp   = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    // One edge to reach the registered outputs, two spare
    task automatic counts(input logic [5:0] rx, input logic [5:0] tx, input logic erx, input logic etx);
        @(posedge aclk);
        rx_element_count <= rx;
        tx_element_count <= tx;
        repeat (3) @(posedge aclk);
        #1;
        `CHK("rx_watermark_irq", erx, rx_watermark_irq)
        `CHK("tx_watermark_irq", etx, tx_watermark_irq)
    endtask : counts

    task automatic t_registers;
        rd(swm_pkg::OFF_MASK_HIGH);
        `CHK("mask reset", {16'h0, swm_pkg::MASK_RESET}, rd_val)
        rd(4'h2);
        `CHK("unmapped resp", swm_pkg::RESP_SLVERR, resp)
        `CHK("unmapped data", 32'h0, rd_val)
        wr(swm_pkg::OFF_MASK_HIGH, 32'h0000FFFF);
        `CHK("mask write resp", swm_pkg::RESP_OKAY, resp)
        rd(swm_pkg::OFF_MASK_HIGH);
        `CHK("mask readback", 32'h0000AFAF, rd_val)
    endtask : t_registers

    task automatic t_rx_watermark;
        wr(swm_pkg::OFF_MASK_HIGH, 32'h00008500);
        counts(6'h04, 6'h00, 1'b0, 1'b0);
        counts(6'h05, 6'h00, 1'b1, 1'b0);
        counts(6'h09, 6'h05, 1'b1, 1'b0);
        wr(swm_pkg::OFF_MASK_HIGH, 32'h00000500);
        counts(6'h09, 6'h00, 1'b0, 1'b0);
    endtask : t_rx_watermark

    task automatic t_tx_watermark;
        wr(swm_pkg::OFF_MASK_HIGH, 32'h00000085);
        counts(6'h00, 6'h04, 1'b0, 1'b0);
        counts(6'h00, 6'h05, 1'b0, 1'b1);
        counts(6'h00, 6'h06, 1'b0, 1'b0);
        wr(swm_pkg::OFF_MASK_HIGH, 32'h00000005);
        counts(6'h00, 6'h05, 1'b0, 1'b0);
    endtask : t_tx_watermark

    task automatic t_invalid_levels;
        // Rx level 0x2F and tx level 0x20 both exceed capacity 16
        wr(swm_pkg::OFF_MASK_HIGH, 32'h0000AFA0);
        counts(6'h3F, 6'h20, 1'b0, 1'b0);
        counts(6'h10, 6'h00, 1'b0, 1'b0);
    endtask : t_invalid_levels

    task automatic t_interrupt;
        // Earlier scenarios left both sticky bits set; no match stands now
        wr(swm_pkg::OFF_IRQ_STATUS, 32'h3);
        rd(swm_pkg::OFF_IRQ_STATUS);
        `CHK("status start", 32'h0, rd_val)
        wr(swm_pkg::OFF_MASK_HIGH, 32'h00008500);
        counts(6'h05, 6'h00, 1'b1, 1'b0);
        rd(swm_pkg::OFF_IRQ_STATUS);
        `CHK("status set", 32'h1, rd_val)
        `CHK("irq masked", 1'b0, irq)
        wr(swm_pkg::OFF_IRQ_ENABLE, 32'h3);
        repeat (2) @(posedge aclk);
        #1;
        `CHK("irq enabled", 1'b1, irq)
        counts(6'h00, 6'h00, 1'b0, 1'b0);
        rd(swm_pkg::OFF_IRQ_STATUS);
        `CHK("status sticky", 32'h1, rd_val)
        wr(swm_pkg::OFF_IRQ_STATUS, 32'h1);
        rd(swm_pkg::OFF_IRQ_STATUS);
        `CHK("status cleared", 32'h0, rd_val)
        `CHK("irq cleared", 1'b0, irq)
    endtask : t_interrupt

    task automatic t_live_counts;
        counts(6'h09, 6'h21, 1'b1, 1'b0);
        rd(swm_pkg::OFF_LIVE);
        `CHK("live counts", 32'h00002109, rd_val)
    endtask : t_live_counts

    // Held enable low: the receive match from before must stay shown
    task automatic t_freeze;
        @(posedge aclk);
        clk_en <= 1'b0;
        counts(6'h00, 6'h00, 1'b1, 1'b0);
        @(posedge aclk);
        clk_en <= 1'b1;
        counts(6'h00, 6'h00, 1'b0, 1'b0);
    endtask : t_freeze

    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_registers();
        t_rx_watermark();
        t_tx_watermark();
        t_invalid_levels();
        t_interrupt();
        t_live_counts();
        t_freeze();
        stop_test();
    end
endmodule : swm_top_bench
`default_nettype wire
